// File: baud_gen.sv
// Baud generator: clock select prescale then divider N
`timescale 1ns/100ps
module baud_gen
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Settings
  input wire logic [1:0] cks,
  input wire logic [7:0] divn,
  input wire logic ext_sel,
  input wire logic ext_rise,
  // Ticks
  tick_if.gen tk
);
  logic [5:0] pre_q, pre_d;
  logic [7:0] div_q, div_d;
  logic [3:0] sub_q, sub_d;
  logic half_q, half_d;
  logic pre_hit, int16;
  logic [5:0] pre_lim;

  // Divide by 4^n before the divider; with n=0 and N=0 this gives mclk/32 bit
  always_comb begin
    unique case (cks)
      2'b00: pre_lim = 6'h00;
      2'b01: pre_lim = 6'h03;
      2'b10: pre_lim = 6'h0F;
      2'b11: pre_lim = 6'h3F;
    endcase
    pre_hit = (pre_q == pre_lim);
    pre_d = pre_hit ? 6'h00 : pre_q + 6'h01;
    // Two divider wraps make one tick16, so N up to 255 needs no wide count
    div_d = div_q;
    half_d = half_q;
    int16 = 1'b0;
    if (pre_hit) begin
      if (div_q == divn) begin
        div_d = 8'h00;
        half_d = !half_q;
        int16 = half_q;
      end else begin
        div_d = div_q + 8'h01;
      end
    end
    // A new frame restarts the grid so its start bit is a full bit long
    if (tk.sync) begin
      pre_d = 6'h00;
      div_d = 8'h00;
      half_d = 1'b0;
    end
  end

  always_comb begin
    tk.tick16 = ext_sel ? ext_rise : int16;
    sub_d = sub_q;
    if (tk.sync) begin
      sub_d = 4'h0;
    end else if (tk.tick16) begin
      sub_d = sub_q + 4'h1;
    end
    tk.bit_tick = tk.tick16 && (sub_q == 4'hF) && !tk.sync;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pre_q <= 6'h00;
      div_q <= 8'h00;
      sub_q <= 4'h0;
      half_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      div_q <= div_d;
      sub_q <= sub_d;
      half_q <= half_d;
    end
  end
endmodule : baud_gen

// File: sct_cfg.svh
// Offsets, field positions, reset values and timing counts of the serial unit
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH
// ==========================================================
// Register word addresses (word index, not scaled by 4)
`define OFS_MODE 4'h0
`define OFS_CTRL 4'h1
`define OFS_STAT 4'h2
`define OFS_TXD 4'h3
`define OFS_BAUD 4'h4
`define OFS_IRQ_STAT 4'h5
`define OFS_IRQ_EN 4'h6
`define OFS_IRQ_CLR 4'h7
`define OFS_RXD 4'h8
// ==========================================================
// Mode register fields
`define MODE_CKS_LO 0
`define MODE_MP 2
`define MODE_STOP 3
`define MODE_PM 4
`define MODE_PE 5
`define MODE_CHR 6
`define MODE_COM 7
// Control register fields
`define CTRL_CLOCK_ENABLE_BIT0 0
`define CTRL_CLOCK_ENABLE_BIT1 1
`define CTRL_TX_END_IRQ_ENABLE 2
`define CTRL_RE 4
`define CTRL_TE 5
`define CTRL_TIE 7
// Status register fields
`define STAT_TX_END_FLAG 2
`define STAT_PER 3
`define STAT_FER 4
`define STAT_OER 5
`define STAT_RX_HOLDING_FULL_FLAG 6
`define STAT_TX_HOLDING_EMPTY_FLAG 7
// Interrupt status bits
`define IRQ_TXE 0
`define IRQ_TX_END_FLAG 1
// ==========================================================
// Reset values
`define RST_MODE 8'h00
`define RST_CTRL 8'h00
`define RST_BAUD 8'hFF
// ==========================================================
// Timing: sixteen sample ticks per bit
`define TICKS_PER_BIT 16
`define CLK_HZ 20000000
`endif

// File: sct_peer.sv
// Remote receiver that decodes frames seen on the transmit line
`timescale 1ns/100ps
module sct_peer #(
  parameter int BIT = 32
) (
  // Clock and line
  input wire logic mclk,
  input wire logic txd,
  // Frame format
  input wire logic len7,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic two_stop,
  // Decoded result
  output logic [7:0] rx_data,
  output logic rx_bad,
  output int rx_cnt
);
  logic [7:0] d;
  // Samples at mid-bit so a line edge never meets a sample
  initial begin
    rx_data = 8'h00;
    rx_bad = 1'b0;
    rx_cnt = 0;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      d = 8'h00;
      if (txd !== 1'b0) rx_bad = 1'b1;
      for (int i = 0; i < (len7 ? 7 : 8); i++) begin
        repeat (BIT) @(posedge mclk);
        d[i] = txd;
      end
      if (par_en) begin
        repeat (BIT) @(posedge mclk);
        if ((^d ^ txd) !== par_odd) rx_bad = 1'b1;
      end
      for (int i = 0; i < (two_stop ? 2 : 1); i++) begin
        repeat (BIT) @(posedge mclk);
        if (txd !== 1'b1) rx_bad = 1'b1;
      end
      rx_data = d;
      rx_cnt++;
    end
  end
endmodule : sct_peer

// File: sct_pkg.sv
// Types shared by the serial transmit unit
package sct_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } tx_state_e;
  typedef logic [7:0] byte_t;
endpackage : sct_pkg

// File: sct_tx_sva.sv
// Port checks for the asynchronous transmit path
`timescale 1ns/100ps
module sct_tx_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Serial pins and interrupt
  input wire logic txd,
  input wire logic sck_in,
  input wire logic sck_out,
  input wire logic sck_oe,
  input wire logic irq
);
  // ==========================================================
  // Shadow of the settings, taken from acknowledged writes
  logic [7:0] ctrl_q;
  logic [7:0] baud_q;
  logic [7:0] en_q;
  logic [1:0] n_q;
  logic last_q;
  logic [31:0] run_q;
  logic [31:0] bit_len;
  assign bit_len = (32'd32 << (2 * n_q)) * ({24'h0, baud_q} + 32'h1);
  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_q <= 8'h00;
      baud_q <= 8'hFF;
      en_q <= 8'h00;
      n_q <= 2'h0;
    end else if (write && !waitrequest) begin
      if (address == 4'h0) n_q <= writedata[1:0];
      if (address == 4'h1) ctrl_q <= writedata[7:0];
      if (address == 4'h4) baud_q <= writedata[7:0];
      if (address == 4'h6) en_q <= writedata[7:0];
    end
  end
  // Length of the current level run on the line
  always_ff @(posedge mclk) begin
    last_q <= txd;
    run_q <= (reset || txd != last_q) ? 32'h1 : run_q + 32'h1;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_txd_write;
    write && !waitrequest && address == 4'h3;
  endsequence
  // A long high run means no frame can still be in flight
  sequence s_line_idle;
    ctrl_q[5] && txd && run_q >= 12 * bit_len;
  endsequence
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("waitrequest held longer than one cycle");
  a_rsvd_zero: assert property (read && !waitrequest && address > 4'h8
    |-> readdata == 32'h0) else $error("unmapped read not zero");
  a_reset_idle: assert property ($fell(reset) |-> txd && sck_out && !irq)
    else $error("outputs not idle after reset");
  a_bit_grid: assert property (
    ctrl_q[5] && !ctrl_q[1] && $rose(txd) |-> run_q[4:0] == 5'h00)
    else $error("low run not a whole number of bit times");
  a_te_off_empty: assert property (
    read && !waitrequest && address == 4'h2 && !ctrl_q[5]
    |-> readdata[7] && readdata[2]) else $error("empty flags clear while off");
  a_load_start: assert property (
    s_line_idle ##0 s_txd_write |-> ##[1:3] !txd)
    else $error("no start bit after data write");
  a_clk_oe: assert property (
    sck_oe == (ctrl_q[0] && !ctrl_q[1])) else $error("clock enable wrong");
  a_irq_en: assert property (
    irq |-> en_q[1:0] != 2'h0) else $error("interrupt with all disabled");
  // Output clock rises half a bit after each bit edge of the line
  a_clk_mid: assert property (
    ctrl_q[5] && !ctrl_q[1] && $rose(sck_out)
    |-> (run_q % bit_len) == (bit_len >> 1))
    else $error("output clock rise not at mid-bit");
endmodule : sct_tx_sva
bind uart_tx_top sct_tx_sva u_sva (.mclk(mclk), .reset(reset),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .txd(txd),
  .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .irq(irq));

// File: testbench.sv
// Self-checking bench for the asynchronous transmit path
`timescale 1ns/100ps
module testbench;
  import sct_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic sck_in = 1'b0;
  logic [31:0] readdata;
  logic [31:0] q;
  logic waitrequest, txd, sck_out, sck_oe, irq, rx_bad;
  logic [7:0] rx_data;
  byte_t fmt = 8'h00;
  byte_t dat [2];
  byte_t modes [5] = '{8'h00, 8'h48, 8'h20, 8'h30, 8'h68};
  // Last pass takes its bit clock from the sixteen-times input pin
  byte_t ctls [5] = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'hA6};
  int rx_cnt, c;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 mclk = ~mclk;
  // External clock, two mclk per tick, left running through setup too
  always @(posedge mclk) sck_in <= !sck_in;
  uart_tx_top u_dut (.mclk(mclk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .txd(txd), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .irq(irq));
  sct_peer #(.BIT(32)) u_peer (.mclk(mclk), .txd(txd), .len7(fmt[6]),
    .par_en(fmt[5]), .par_odd(fmt[4]), .two_stop(fmt[3]),
    .rx_data(rx_data), .rx_bad(rx_bad), .rx_cnt(rx_cnt));
  // ==========================================================
  // Reporting
  task finish_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  // ==========================================================
  // Bus and line helpers
  task automatic bus(input logic wr, input logic [3:0] a, input byte_t d);
    int t;
    t = 0;
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    write <= wr;
    read <= !wr;
    // Request stands until the edge that sees waitrequest low
    do begin
      @(posedge mclk);
      t++;
    end while (waitrequest !== 1'b0 && t < 100);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (t >= 100) chk("bus answer", 32'h0, 32'h1);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e, string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask : rd
  // Status poll; the bound keeps a stuck flag from hanging the run
  task automatic poll(input int b);
    int t;
    t = 0;
    do begin
      bus(1'b0, 4'h2, 8'h00);
      t++;
    end while (q[b] !== 1'b1 && t < 500);
    chk("status poll", 32'h1, {31'h0, q[b]});
  endtask : poll
  task automatic wait_rx(input int n, input byte_t e);
    int t;
    t = 0;
    while (rx_cnt < n && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    chk("rx count", n, rx_cnt);
    chk("rx data", {24'h0, e}, {24'h0, rx_data});
    chk("rx frame", 32'h0, {31'h0, rx_bad});
  endtask : wait_rx
  function automatic byte_t exp_rx(byte_t d, byte_t m);
    return m[6] ? {1'b0, d[6:0]} : d;
  endfunction : exp_rx
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(48965));
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(4'h0, 32'h00, "mode");
    rd(4'h1, 32'h00, "ctrl");
    rd(4'h4, 32'hFF, "baud");
    rd(4'h2, 32'h84, "status");
    rd(4'h9, 32'h00, "unmapped");
    bus(1'b1, 4'h5, 8'h03);
    rd(4'h5, 32'h00, "irq status");
    $display("test reset done");
    foreach (modes[m]) begin
      bus(1'b1, 4'h1, 8'h00);
      fmt = modes[m];
      bus(1'b1, 4'h0, fmt);
      bus(1'b1, 4'h4, 8'h00);
      bus(1'b1, 4'h6, 8'h03);
      bus(1'b1, 4'h1, ctls[m]);
      dat[0] = byte_t'($urandom);
      dat[1] = byte_t'($urandom);
      // A quiet line first, so the load check sees a long idle run
      repeat (12 * 32) @(posedge mclk);
      c = rx_cnt;
      bus(1'b1, 4'h3, dat[0]);
      poll(7);
      bus(1'b1, 4'h3, dat[1]);
      wait_rx(c + 1, exp_rx(dat[0], fmt));
      wait_rx(c + 2, exp_rx(dat[1], fmt));
      poll(2);
      chk("irq", 32'h1, {31'h0, irq});
      rd(4'h5, 32'h03, "irq status");
      bus(1'b1, 4'h7, 8'h03);
      rd(4'h5, 32'h00, "irq status");
      chk("irq", 32'h0, {31'h0, irq});
      $display("test mode %0d done", m);
    end
    bus(1'b1, 4'h6, 8'h00);
    dat[0] = byte_t'($urandom);
    bus(1'b1, 4'h3, dat[0]);
    wait_rx(c + 3, exp_rx(dat[0], fmt));
    poll(2);
    chk("masked irq", 32'h0, {31'h0, irq});
    rd(4'h5, 32'h03, "irq status");
    bus(1'b1, 4'h1, 8'h00);
    rd(4'h2, 32'h84, "status");
    chk("idle line", 32'h1, {31'h0, txd});
    $display("test mask and disable done");
    finish_test();
  end
endmodule : testbench

// File: tick_if.sv
// Bit tick bundle between baud generator and transmitter
`timescale 1ns/100ps
interface tick_if;
  logic tick16;
  logic bit_tick;
  logic sync;
  modport gen (output tick16, output bit_tick, input sync);
  modport use_ (input tick16, input bit_tick, output sync);
endinterface : tick_if

// File: uart_tx_top.sv
// Asynchronous transmit path with Avalon-MM register slave
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "sct_cfg.svh"
// What this block does
// - Start low, LSB first, parity, high stops
// - Holding register ahead of independent shifter
// - Serial clock internal or external pin
// - Clock out at bit rate, rising mid-bit
// - n0 N0 gives clock divided by 32
// - Two-bit select and eight-bit divider
// - Synchronous fastest rate is clock divided by 32
// - Transmit disable sets holding empty flag
// - Receive disable keeps receive flags, data
// - Empty flag low loads shift register
// - Load sets empty, starts, raises interrupt
// - Stop time reload gives gapless frames
// - Nothing pending: end flag, idle high
// - Holding write clears empty flag
module uart_tx_top
  import sct_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial pins
  output logic txd,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // Interrupt
  output logic irq
);
  tick_if tk ();

  byte_t mode_q, mode_d, ctrl_q, ctrl_d, baud_q, baud_d;
  byte_t thr_q, thr_d, tsr_q, tsr_d, rxd_q;
  logic tx_holding_empty_flag_q, tx_holding_empty_flag_d, tx_end_flag_q, tx_end_flag_d;
  logic [1:0] ist_q, ist_d, ien_q, ien_d;
  logic [3:0] rxflags_q;
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  tx_state_e st_q, st_d;
  logic [2:0] bit_q, bit_d;
  logic par_q, par_d, stop2_q, stop2_d;
  logic txd_q, txd_d, sck_q, sck_d;
  logic [3:0] ph_q, ph_d;
  logic s1_q, s2_q, s3_q;
  logic ext_sel, ext_rise, wr_stb, rd_stb, ev_txe, ev_tx_end_flag;
  logic [2:0] last_bit;

  // ==========================================================
  // Pin synchroniser for external clock
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= sck_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // External clock only in async mode with clock_enable_bit1 set
  assign ext_sel = !mode_q[`MODE_COM] && ctrl_q[`CTRL_CLOCK_ENABLE_BIT1];
  assign ext_rise = s2_q && !s3_q;

  baud_gen u_baud (
    .mclk(mclk),
    .reset(reset),
    .cks(mode_q[1:0]),
    .divn(baud_q),
    .ext_sel(ext_sel),
    .ext_rise(ext_rise),
    .tk(tk)
  );

  // ==========================================================
  // Avalon-MM slave: one wait cycle, answer on the second edge
  assign wr_stb = write && ack_q;
  assign rd_stb = read && ack_q;
  assign waitrequest = (read || write) && !ack_q;
  assign readdata = rd_q;

  always_comb begin
    ack_d = (read || write) && !ack_q;
    rd_d = rd_q;
    if (read && !ack_q) begin
      unique case (address)
        `OFS_MODE: rd_d = {24'h000000, mode_q};
        `OFS_CTRL: rd_d = {24'h000000, ctrl_q};
        `OFS_STAT: rd_d = {24'h000000, tx_holding_empty_flag_q, rxflags_q, tx_end_flag_q, 2'b00};
        `OFS_TXD: rd_d = {24'h000000, thr_q};
        `OFS_BAUD: rd_d = {24'h000000, baud_q};
        `OFS_IRQ_STAT: rd_d = {30'h00000000, ist_q};
        `OFS_IRQ_EN: rd_d = {30'h00000000, ien_q};
        `OFS_RXD: rd_d = {24'h000000, rxd_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Register file
  always_comb begin
    mode_d = mode_q;
    ctrl_d = ctrl_q;
    baud_d = baud_q;
    thr_d = thr_q;
    ien_d = ien_q;
    if (wr_stb) begin
      unique case (address)
        `OFS_MODE: mode_d = writedata[7:0];
        `OFS_CTRL: ctrl_d = writedata[7:0];
        `OFS_BAUD: baud_d = writedata[7:0];
        `OFS_TXD: thr_d = writedata[7:0];
        `OFS_IRQ_EN: ien_d = writedata[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Transmit sequencer
  always_comb begin
    // Character length 8 or 7 bits
    last_bit = mode_q[`MODE_CHR] ? 3'h6 : 3'h7;
    st_d = st_q;
    bit_d = bit_q;
    tsr_d = tsr_q;
    par_d = par_q;
    stop2_d = stop2_q;
    txd_d = txd_q;
    tx_holding_empty_flag_d = tx_holding_empty_flag_q;
    tx_end_flag_d = tx_end_flag_q;
    ev_txe = 1'b0;
    ev_tx_end_flag = 1'b0;
    if (st_q == TX_IDLE && !tx_holding_empty_flag_q && ctrl_q[`CTRL_TE]) begin
      tsr_d = thr_q;
      tx_holding_empty_flag_d = 1'b1;
      ev_txe = 1'b1;
      tx_end_flag_d = 1'b0;
      par_d = mode_q[`MODE_PM];
      st_d = TX_START;
      txd_d = 1'b0;
    end else if (tk.bit_tick && st_q != TX_IDLE) begin
      unique case (st_q)
        TX_START: begin
          st_d = TX_DATA;
          bit_d = 3'h0;
          txd_d = tsr_q[0];
          par_d = par_q ^ tsr_q[0];
        end
        TX_DATA: begin
          if (bit_q == last_bit) begin
            st_d = mode_q[`MODE_PE] ? TX_PAR : TX_STOP;
            txd_d = mode_q[`MODE_PE] ? par_q : 1'b1;
            stop2_d = mode_q[`MODE_STOP];
          end else begin
            bit_d = bit_q + 3'h1;
            txd_d = tsr_q[bit_q + 3'h1];
            par_d = par_q ^ tsr_q[bit_q + 3'h1];
          end
        end
        TX_PAR: begin
          st_d = TX_STOP;
          txd_d = 1'b1;
          stop2_d = mode_q[`MODE_STOP];
        end
        TX_STOP: begin
          if (stop2_q) begin
            stop2_d = 1'b0;
          end else if (!tx_holding_empty_flag_q && ctrl_q[`CTRL_TE]) begin
            tsr_d = thr_q;
            tx_holding_empty_flag_d = 1'b1;
            ev_txe = 1'b1;
            par_d = mode_q[`MODE_PM];
            st_d = TX_START;
            txd_d = 1'b0;
          end else begin
            st_d = TX_IDLE;
            tx_end_flag_d = 1'b1;
            ev_tx_end_flag = 1'b1;
          end
        end
        default: st_d = TX_IDLE;
      endcase
    end
    if (st_q == TX_STOP && tk.bit_tick && !stop2_q) begin
      txd_d = (st_d == TX_START) ? 1'b0 : 1'b1;
    end
    if (!ctrl_q[`CTRL_TE]) begin
      // Disable aborts frame; line idles high, break is a port function
      st_d = TX_IDLE;
      txd_d = 1'b1;
      tx_holding_empty_flag_d = 1'b1;
      tx_end_flag_d = 1'b1;
    end else if (wr_stb && address == `OFS_TXD) begin
      tx_holding_empty_flag_d = 1'b0;
      tx_end_flag_d = 1'b0;
    end
  end

  // ==========================================================
  // Output clock: bit rate, rising edge mid-bit
  always_comb begin
    ph_d = ph_q;
    if (tk.bit_tick || st_q == TX_IDLE) begin
      ph_d = 4'h0;
    end else if (tk.tick16) begin
      ph_d = ph_q + 4'h1;
    end
    // Taken from next values so the registered edge lands on mid-bit
    sck_d = (ph_d >= 4'h8) || st_d == TX_IDLE;
  end
  assign tk.sync = (st_q == TX_IDLE) && !tx_holding_empty_flag_q && ctrl_q[`CTRL_TE];
  assign sck_oe = !ext_sel && ctrl_q[`CTRL_CLOCK_ENABLE_BIT0];
  assign sck_out = sck_q;
  assign txd = txd_q;

  // ==========================================================
  // Interrupt status: set wins over clear
  always_comb begin
    ist_d = ist_q;
    if (wr_stb && address == `OFS_IRQ_CLR) begin
      ist_d = ist_q & ~writedata[1:0];
    end
    if (ev_txe && ctrl_q[`CTRL_TIE]) begin
      ist_d[`IRQ_TXE] = 1'b1;
    end
    if (ev_tx_end_flag && ctrl_q[`CTRL_TX_END_IRQ_ENABLE]) begin
      ist_d[`IRQ_TX_END_FLAG] = 1'b1;
    end
  end
  assign irq = |(ist_q & ien_q);

  // Receive flags and data belong to the receiver; disabling keeps them
  assign rxflags_q = 4'h0;
  assign rxd_q = 8'h00;

  always_ff @(posedge mclk) begin
    if (reset) begin
      mode_q <= `RST_MODE;
      ctrl_q <= `RST_CTRL;
      baud_q <= `RST_BAUD;
      thr_q <= 8'hFF;
      tsr_q <= 8'hFF;
      tx_holding_empty_flag_q <= 1'b1;
      tx_end_flag_q <= 1'b1;
      ist_q <= 2'h0;
      ien_q <= 2'h0;
      ack_q <= 1'b0;
      rd_q <= 32'h00000000;
      st_q <= TX_IDLE;
      bit_q <= 3'h0;
      par_q <= 1'b0;
      stop2_q <= 1'b0;
      txd_q <= 1'b1;
      sck_q <= 1'b1;
      ph_q <= 4'h0;
    end else begin
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
      baud_q <= baud_d;
      thr_q <= thr_d;
      tsr_q <= tsr_d;
      tx_holding_empty_flag_q <= tx_holding_empty_flag_d;
      tx_end_flag_q <= tx_end_flag_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      st_q <= st_d;
      bit_q <= bit_d;
      par_q <= par_d;
      stop2_q <= stop2_d;
      txd_q <= txd_d;
      sck_q <= sck_d;
      ph_q <= ph_d;
    end
  end
endmodule : uart_tx_top
